//--- common/ebic_defines.svh
`ifndef EBIC_DEFINES_SVH
`define EBIC_DEFINES_SVH

// last phase index of the machine cycle, which lasts 4 system clock cycles (125 MHz / 4)
`define EBIC_MC_DIV        2'h3
`define EBIC_MC_HALF       2'h2
// least software wait count at which the ready input is honoured
`define EBIC_READY_MIN_WS  3'h2
// address field layout
`define EBIC_ADDR_LO_W     16
`define EBIC_ADDR_HI_W     7
// request fifo depth
`define EBIC_FIFO_DEPTH    8
// idle level of an active-low pin
`define EBIC_PIN_IDLE      1'h1

`endif

//--- common/ebic_pkg.sv
package ebic_pkg;

  // external space addressed by an access
  typedef enum logic [1:0] {
    EBIC_SPACE_DATA = 2'h0,
    EBIC_SPACE_PROG = 2'h1,
    EBIC_SPACE_IO   = 2'h2
  } ebic_space_e;

  // bus sequencer states, one-hot
  typedef enum logic [4:0] {
    EBIC_ST_IDLE   = 5'h01,
    EBIC_ST_ACCESS = 5'h02,
    EBIC_ST_SWAIT  = 5'h04,
    EBIC_ST_XWAIT  = 5'h08,
    EBIC_ST_HOLD   = 5'h10
  } ebic_state_e;

  // one access request from the core
  typedef struct packed {
    ebic_space_e  space;
    logic         write;
    logic         fetch;
    logic [2:0]   wait_states;
    logic [22:0]  addr;
    logic [15:0]  wdata;
  } ebic_req_s;

endpackage

//--- design/ebic_fifo.sv
`timescale 1ns/1ps
// small synchronous fifo, read data held in a register
module ebic_fifo #(
  parameter int WIDTH = 46,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic             push, pop;

  // honest full and empty from the occupancy count
  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = out_q;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // next pointers, count and head register
  always_comb begin
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = AW'(0) + cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (cnt_d == '0) begin
      out_d = out_q;
    end else if (push && (cnt_q == '0 || (pop && cnt_q == (AW+1)'(1)))) begin
      out_d = in_data_i;
    end else begin
      out_d = mem_q[rd_d];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      out_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  // storage array
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

//--- design/ebic_ctrl.sv
`timescale 1ns/1ps
`include "ebic_defines.svh"
module ebic_ctrl (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               req_valid_i,
  output logic                    req_ready_o,
  input  wire ebic_pkg::ebic_req_s req_i,
  output logic                    rsp_valid_o,
  output logic [15:0]             rsp_data_o,
  output logic [22:0]             addr_o,
  output logic                    addr_oe_o,
  input  wire logic [15:0]        data_i,
  output logic [15:0]             data_o,
  output logic                    data_oe_o,
  output logic                    data_space_select_n_o,
  output logic                    program_space_select_n_o,
  output logic                    io_space_select_n_o,
  output logic                    memory_strobe_n_o,
  output logic                    io_access_strobe_n_o,
  output logic                    rd_wr_n_o,
  output logic                    ctrl_oe_o,
  input  wire logic               ready_i,
  input  wire logic               hold_req_n_i,
  output logic                    bus_release_grant_n_o,
  output logic                    wait_count_done_n_o,
  output logic                    instr_fetch_n_o,
  output logic                    machine_clock_out_o,
  output logic                    aux_oe_o,
  input  wire logic               off_n_i
);

  ebic_pkg::ebic_state_e state_q, state_d;
  ebic_pkg::ebic_req_s   head, cur_q, cur_d;
  logic [2:0]            cnt_q, cnt_d;
  logic [1:0]            phase_q, phase_d;
  logic                  rsp_valid_q, rsp_valid_d;
  logic [15:0]           rsp_data_q, rsp_data_d;
  logic                  head_valid, pop, mc_en, busy, ready_used, last_sw;
  logic [1:0]            ready_s, hold_s, off_s;
  logic [15:0]           data_s1, data_s2;

  // request buffer between core and bus sequencer
  ebic_fifo #(
    .WIDTH ($bits(ebic_pkg::ebic_req_s)),
    .DEPTH (`EBIC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   (req_i),
    .out_valid_o (head_valid),
    .out_ready_i (pop),
    .out_data_o  (head)
  );

  // two-flop synchronisers for pin inputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ready_s <= 2'h3;
      hold_s  <= 2'h3;
      off_s   <= 2'h3;
      data_s1 <= 16'h0000;
      data_s2 <= 16'h0000;
    end else begin
      ready_s <= {ready_s[0], ready_i};
      hold_s  <= {hold_s[0], hold_req_n_i};
      off_s   <= {off_s[0], off_n_i};
      data_s1 <= data_i;
      data_s2 <= data_s1;
    end
  end

  // machine cycle divider, enable on the last phase
  assign mc_en   = (phase_q == `EBIC_MC_DIV);
  assign phase_d = mc_en ? 2'h0 : 2'(phase_q + 2'h1);
  assign machine_clock_out_o = (phase_q < `EBIC_MC_HALF);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ready counts only with enough programmed wait states
  assign ready_used = (cur_q.wait_states >= `EBIC_READY_MIN_WS);
  assign last_sw    = (state_q == ebic_pkg::EBIC_ST_SWAIT) && (cnt_q == 3'h1);
  assign busy       = (state_q == ebic_pkg::EBIC_ST_ACCESS) || (state_q == ebic_pkg::EBIC_ST_SWAIT)
                   || (state_q == ebic_pkg::EBIC_ST_XWAIT);
  assign pop        = mc_en && (state_q == ebic_pkg::EBIC_ST_IDLE) && hold_s[1] && head_valid;

  // bus sequencer next state
  always_comb begin
    state_d     = state_q;
    cur_d       = cur_q;
    cnt_d       = cnt_q;
    rsp_valid_d = 1'b0;
    rsp_data_d  = rsp_data_q;
    if (mc_en) begin
      case (state_q)
        ebic_pkg::EBIC_ST_IDLE: begin
          if (!hold_s[1]) begin
            state_d = ebic_pkg::EBIC_ST_HOLD;
          end else if (head_valid) begin
            state_d = ebic_pkg::EBIC_ST_ACCESS;
            cur_d   = head;
          end
        end
        ebic_pkg::EBIC_ST_ACCESS: begin
          if (cur_q.wait_states == 3'h0) begin
            state_d     = ebic_pkg::EBIC_ST_IDLE;
            rsp_valid_d = 1'b1;
            rsp_data_d  = data_s2;
          end else begin
            state_d = ebic_pkg::EBIC_ST_SWAIT;
            cnt_d   = cur_q.wait_states;
          end
        end
        ebic_pkg::EBIC_ST_SWAIT: begin
          if (cnt_q != 3'h1) begin
            cnt_d = 3'(cnt_q - 3'h1);
          end else if (ready_used && !ready_s[1]) begin
            state_d = ebic_pkg::EBIC_ST_XWAIT;
          end else begin
            state_d     = ebic_pkg::EBIC_ST_IDLE;
            rsp_valid_d = 1'b1;
            rsp_data_d  = data_s2;
          end
        end
        ebic_pkg::EBIC_ST_XWAIT: begin
          if (ready_s[1]) begin
            state_d     = ebic_pkg::EBIC_ST_IDLE;
            rsp_valid_d = 1'b1;
            rsp_data_d  = data_s2;
          end
        end
        ebic_pkg::EBIC_ST_HOLD: begin
          if (hold_s[1]) begin
            state_d = ebic_pkg::EBIC_ST_IDLE;
          end
        end
        default: begin
          state_d = ebic_pkg::EBIC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q     <= ebic_pkg::EBIC_ST_IDLE;
      cur_q       <= '0;
      cnt_q       <= 3'h0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 16'h0000;
    end else begin
      state_q     <= state_d;
      cur_q       <= cur_d;
      cnt_q       <= cnt_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q  <= rsp_data_d;
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o  = rsp_data_q;

  // space selects and strobes follow the access window
  assign data_space_select_n_o    = !(busy && cur_q.space == ebic_pkg::EBIC_SPACE_DATA);
  assign program_space_select_n_o = !(busy && cur_q.space == ebic_pkg::EBIC_SPACE_PROG);
  assign io_space_select_n_o      = !(busy && cur_q.space == ebic_pkg::EBIC_SPACE_IO);
  assign memory_strobe_n_o        = !(busy && cur_q.space != ebic_pkg::EBIC_SPACE_IO);
  assign io_access_strobe_n_o     = !(busy && cur_q.space == ebic_pkg::EBIC_SPACE_IO);
  assign rd_wr_n_o                = !(busy && cur_q.write);
  assign instr_fetch_n_o          = !(busy && cur_q.fetch);
  assign wait_count_done_n_o      = !(last_sw && ready_used);
  assign bus_release_grant_n_o    = (state_q != ebic_pkg::EBIC_ST_HOLD);

  // address: upper lines only carry program space addresses
  assign addr_o[15:0]  = cur_q.addr[15:0];
  assign addr_o[22:16] = (cur_q.space == ebic_pkg::EBIC_SPACE_PROG) ? cur_q.addr[22:16] : 7'h00;
  assign data_o        = cur_q.wdata;

  // output enables: hold floats bus lines, tristate input floats everything
  assign ctrl_oe_o = off_s[1] && (state_q != ebic_pkg::EBIC_ST_HOLD);
  assign addr_oe_o = ctrl_oe_o;
  assign aux_oe_o  = off_s[1];
  assign data_oe_o = ctrl_oe_o && busy && cur_q.write && hold_s[1];

  // checks
  sequence s_hold_seen;
    mc_en && state_q == ebic_pkg::EBIC_ST_IDLE && !hold_s[1];
  endsequence
  sequence s_hold_entered;
    ##1 state_q == ebic_pkg::EBIC_ST_HOLD;
  endsequence
  sequence s_wcd_span;
    !wait_count_done_n_o [*4] ##1 wait_count_done_n_o;
  endsequence

  AST_SEL_ONLY_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !busy |-> (data_space_select_n_o && program_space_select_n_o && io_space_select_n_o))
    else $error("space select low outside an access");
  AST_MEMORY_STROBE_N_MEM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !memory_strobe_n_o |-> busy && io_access_strobe_n_o)
    else $error("memory strobe low outside a memory access");
  AST_IO_ACCESS_STROBE_N_IO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !io_access_strobe_n_o |-> !io_space_select_n_o && memory_strobe_n_o)
    else $error("io strobe without io select");
  AST_RW_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_wr_n_o |-> busy && cur_q.write)
    else $error("write direction outside a write");
  AST_READY_GATED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == ebic_pkg::EBIC_ST_XWAIT |-> cur_q.wait_states >= `EBIC_READY_MIN_WS)
    else $error("external wait with too few software waits");
  AST_NO_EARLY_READY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mc_en && state_q == ebic_pkg::EBIC_ST_SWAIT && cnt_q > 3'h1 |=> state_q == ebic_pkg::EBIC_ST_SWAIT)
    else $error("software wait cut short");
  AST_MSC_LAST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wait_count_done_n_o |-> last_sw && cur_q.wait_states >= `EBIC_READY_MIN_WS)
    else $error("wait done outside the last wait state");
  AST_MSC_SPAN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mc_en && state_q == ebic_pkg::EBIC_ST_SWAIT && cnt_q == 3'h2 |=> s_wcd_span)
    else $error("wait done not low for exactly the last wait state");
  AST_READY_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mc_en && state_q == ebic_pkg::EBIC_ST_SWAIT && cnt_q == 3'h1 && cur_q.wait_states < `EBIC_READY_MIN_WS
    |=> state_q == ebic_pkg::EBIC_ST_IDLE && rsp_valid_o)
    else $error("ready honoured with too few software waits");
  AST_XWAIT_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mc_en && state_q == ebic_pkg::EBIC_ST_XWAIT && ready_s[1] |=> state_q == ebic_pkg::EBIC_ST_IDLE && rsp_valid_o)
    else $error("ready high did not end the access");
  AST_GRANT_FLOAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !bus_release_grant_n_o |-> !ctrl_oe_o && !addr_oe_o && !data_oe_o)
    else $error("grant while driving the bus");
  AST_HOLD_BETWEEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_hold_seen |-> s_hold_entered)
    else $error("hold request not granted when idle");
  AST_OFF_FLOAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !off_s[1] |-> !aux_oe_o && !ctrl_oe_o && !data_oe_o)
    else $error("driving pins while tristate input low");
  AST_CLK_RISE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mc_en |=> $rose(machine_clock_out_o) ##2 $fell(machine_clock_out_o))
    else $error("clock output not at machine rate");
  AST_FETCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !instr_fetch_n_o |-> busy && cur_q.fetch)
    else $error("fetch flag without an instruction access");
  AST_DATA_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    data_oe_o |-> hold_s[1] && cur_q.write && busy)
    else $error("data driven when it must float");

endmodule

//--- tb/ebic_ext_mem.sv
`timescale 1ns/1ps
// external memory and i/o device standing on the far side of the bus
module ebic_ext_mem (
  input  wire logic        clk_i,
  input  wire logic [1:0]  ready_mode_i,
  input  wire logic [22:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wdata_oe_i,
  input  wire logic [2:0]  sel_n_i,
  input  wire logic        strobe_n_i,
  input  wire logic        rd_wr_n_i,
  input  wire logic        wcd_n_i,
  output logic      [15:0] bus_o,
  output logic             ready_o
);
  logic [15:0] mem [16];
  logic [15:0] last_q = 16'h0000;
  int          acc_cnt = 0;
  logic        rd;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hA500 + 16'(i);
  // data wire: controller write, device read, otherwise a toggling float pattern
  assign rd    = (sel_n_i != 3'h7) && !strobe_n_i && rd_wr_n_i;
  assign bus_o = wdata_oe_i ? wdata_i : (rd ? mem[addr_i[3:0]] : ~last_q);
  // ready is prompt, looped from wait-done, or held low for the first 24 clocks
  assign ready_o = (ready_mode_i == 2'h0) ? 1'b1 :
                   (ready_mode_i == 2'h1) ? wcd_n_i : (acc_cnt >= 24);
  // access length counter and write capture
  always @(posedge clk_i) begin
    last_q  <= bus_o;
    acc_cnt <= (sel_n_i == 3'h7) ? 0 : acc_cnt + 1;
    if (!strobe_n_i && !rd_wr_n_i && wdata_oe_i) mem[addr_i[3:0]] <= wdata_i;
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic                clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                req_valid_i = 1'b0;
  logic                hold_req_n_i = 1'b1;
  logic                off_n_i = 1'b1;
  logic                mon_clr = 1'b0;
  logic [1:0]          ready_mode = 2'h0;
  ebic_pkg::ebic_req_s req_i = '0;
  logic                req_ready_o, rsp_valid_o, addr_oe, data_oe, ctrl_oe, aux_oe, ready_i, mco;
  logic                ds_n, ps_n, is_n, ms_n, ios_n, rw_n, grant_n, wcd_n, fetch_n;
  logic                mco_prev = 1'b0;
  logic [2:0]          sel_n;
  logic [7:0]          seen = 8'h00;
  logic [15:0]         rsp_data_o, bus, wdata;
  logic [22:0]         addr_o;
  int                  error_cnt = 0, n_tests = 0, sel_cnt = 0, wcd_cnt = 0, per_cnt = 0, cyc = 0;
  bit                  clk_seen = 1'b0;

  always #4 clk_i = ~clk_i;
  assign sel_n = {is_n, ps_n, ds_n};

  ebic_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .addr_o(addr_o), .addr_oe_o(addr_oe),
    .data_i(bus), .data_o(wdata), .data_oe_o(data_oe), .data_space_select_n_o(ds_n),
    .program_space_select_n_o(ps_n), .io_space_select_n_o(is_n), .memory_strobe_n_o(ms_n),
    .io_access_strobe_n_o(ios_n), .rd_wr_n_o(rw_n), .ctrl_oe_o(ctrl_oe), .ready_i(ready_i),
    .hold_req_n_i(hold_req_n_i), .bus_release_grant_n_o(grant_n), .wait_count_done_n_o(wcd_n),
    .instr_fetch_n_o(fetch_n), .machine_clock_out_o(mco), .aux_oe_o(aux_oe), .off_n_i(off_n_i));

  ebic_ext_mem mem_dev (.clk_i(clk_i), .ready_mode_i(ready_mode), .addr_i(addr_o), .wdata_i(wdata),
    .wdata_oe_i(data_oe), .sel_n_i(sel_n), .strobe_n_i(ms_n & ios_n), .rd_wr_n_i(rw_n), .wcd_n_i(wcd_n),
    .bus_o(bus), .ready_o(ready_i));

  // bus watcher: access and wait-done lengths, pins seen low, pin relations, clock period
  always @(negedge clk_i) begin
    if (mon_clr) begin
      sel_cnt = 0;
      wcd_cnt = 0;
      seen = 8'h00;
    end else if (rst_n_i) begin
      if (sel_n != 3'h7) sel_cnt++;
      if (!wcd_n) wcd_cnt++;
      seen |= {(sel_n != 3'h7) && (addr_o[22:16] != 7'h00), ~fetch_n, ~rw_n, ~ios_n, ~ms_n, ~sel_n};
      `CHK("one_select", 1'b1, $countones(~sel_n) <= 1)
      `CHK("mem_strobe", 1'b1, ms_n | !(ds_n & ps_n))
      `CHK("io_strobe", 1'b1, ios_n | !is_n)
      `CHK("rd_wr", 1'b1, rw_n | (sel_n != 3'h7))
      `CHK("fetch", 1'b1, fetch_n | (sel_n != 3'h7))
      `CHK("grant", 1'b1, grant_n | (!ctrl_oe && !addr_oe && !data_oe && sel_n == 3'h7))
    end
    // clock period keeps counting through a watcher clear
    if (rst_n_i) begin
      per_cnt++;
      if (mco && !mco_prev) begin
        if (clk_seen) `CHK("clk_period", 4, per_cnt)
        per_cnt = 0;
        clk_seen = 1'b1;
      end
      mco_prev = mco;
    end
  end

  // run limit
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // offer one request and hold it until the fifo takes it
  task automatic push(input ebic_pkg::ebic_req_s r);
    logic tk;
    req_valid_i = 1'b1;
    req_i = r;
    tk = 1'b0;
    for (int n = 0; n < 300 && !tk; n++) begin
      tk = (req_ready_o === 1'b1);
      step(1);
    end
    if (!tk) begin error_cnt++; close_out(); end
  endtask

  task automatic wait_rsp();
    int n;
    n = 0;
    do begin
      step(1);
      n++;
      if (n > 300) begin error_cnt++; close_out(); end
    end while (rsp_valid_o !== 1'b1);
  endtask

  // one access, judged by pins seen, length, wait-done length and read data
  task automatic do_acc(input ebic_pkg::ebic_space_e sp, input logic wr, fe, input logic [2:0] ws,
                        input logic [22:0] ad, input logic [15:0] wd, ex, input int exp_len, output int len);
    logic [7:0] es;
    es = {sp == ebic_pkg::EBIC_SPACE_PROG && ad[22:16] != 7'h00, fe, wr,
          sp == ebic_pkg::EBIC_SPACE_IO, sp != ebic_pkg::EBIC_SPACE_IO, 3'h1 << sp};
    mon_clr = 1'b1;
    step(1);
    mon_clr = 1'b0;
    push('{sp, wr, fe, ws, ad, wd});
    req_valid_i = 1'b0;
    wait_rsp();
    step(2);
    `CHK("seen", es, seen)
    if (!wr) `CHK("rdata", ex, rsp_data_o)
    if (exp_len != 0) `CHK("acc_len", exp_len, sel_cnt)
    `CHK("wcd_len", (ws >= 3'h2) ? 4 : 0, wcd_cnt)
    len = sel_cnt;
  endtask

  task automatic t_spaces();
    int len;
    for (int s = 0; s < 3; s++) do_acc(ebic_pkg::ebic_space_e'(s), 1'b0, 1'b0, 3'h0, 23'h7F0003, 16'h0000,
                                       16'hA503, 4, len);
  endtask

  // access under way when hold arrives, then eight queued requests released in order
  task automatic t_hold();
    ebic_pkg::ebic_req_s r;
    int n;
    r = '{ebic_pkg::EBIC_SPACE_DATA, 1'b0, 1'b0, 3'h3, 23'h000008, 16'h0000};
    push(r);
    req_valid_i = 1'b0;
    for (n = 0; n < 100 && ds_n !== 1'b0; n++) step(1);
    hold_req_n_i = 1'b0;
    wait_rsp();
    `CHK("hold_rdata", 16'hA508, rsp_data_o)
    for (n = 0; n < 20 && grant_n !== 1'b0; n++) step(1);
    `CHK("grant_low", 1'b0, grant_n)
    `CHK("floated", 3'h0, {ctrl_oe, addr_oe, data_oe})
    r.wait_states = 3'h0;
    for (int i = 0; i < 8; i++) begin
      r.addr = 23'(i);
      push(r);
    end
    `CHK("fifo_full", 1'b0, req_ready_o)
    req_valid_i = 1'b0;
    step(12);
    `CHK("still_held", 1'b0, grant_n)
    hold_req_n_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wait_rsp();
      `CHK("fifo_order", 16'hA500 + 16'(i), rsp_data_o)
    end
    `CHK("grant_high", 1'b1, grant_n)
  endtask

  task automatic t_waits();
    int len;
    do_acc(ebic_pkg::EBIC_SPACE_IO, 1'b1, 1'b0, 3'h1, 23'h5, 16'h3C5A, 16'h0, 8, len);
    do_acc(ebic_pkg::EBIC_SPACE_DATA, 1'b0, 1'b0, 3'h1, 23'h5, 16'h0, 16'h3C5A, 8, len);
    do_acc(ebic_pkg::EBIC_SPACE_PROG, 1'b0, 1'b1, 3'h0, 23'h1, 16'h0, 16'hA501, 4, len);
    do_acc(ebic_pkg::EBIC_SPACE_PROG, 1'b0, 1'b0, 3'h2, 23'h2, 16'h0, 16'hA502, 12, len);
    ready_mode = 2'h1;
    do_acc(ebic_pkg::EBIC_SPACE_DATA, 1'b0, 1'b0, 3'h2, 23'h2, 16'h0, 16'hA502, 16, len);
    do_acc(ebic_pkg::EBIC_SPACE_DATA, 1'b0, 1'b0, 3'h3, 23'h2, 16'h0, 16'hA502, 20, len);
    ready_mode = 2'h2;
    do_acc(ebic_pkg::EBIC_SPACE_DATA, 1'b0, 1'b0, 3'h1, 23'h4, 16'h0, 16'hA504, 8, len);
    do_acc(ebic_pkg::EBIC_SPACE_DATA, 1'b0, 1'b0, 3'h3, 23'h4, 16'h0, 16'hA504, 0, len);
    `CHK("slow_len", 1'b1, len >= 24 && len <= 32 && len % 4 == 0)
    ready_mode = 2'h0;
  endtask

  task automatic t_off();
    off_n_i = 1'b0;
    step(6);
    `CHK("off_oe", 3'h0, {ctrl_oe, addr_oe, aux_oe})
    off_n_i = 1'b1;
    step(6);
    `CHK("on_oe", 3'h7, {ctrl_oe, addr_oe, aux_oe})
  endtask

  initial begin
    step(4);
    rst_n_i = 1'b1;
    t_spaces();
    t_hold();
    t_waits();
    t_off();
    close_out();
  end
endmodule
